// File: verilog/isd_dma.sv
// Five-channel serial receive DMA with shared command sequencer
`timescale 1ns/1ps
`default_nettype none
module isd_dma #(
  parameter int US_SEC = isd_pkg::US_PER_SEC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial receive lines
  input wire logic [isd_pkg::NCH-1:0] rx_dat,
  input wire logic [isd_pkg::NCH-1:0] rx_frm,
  // Serial command lines
  output logic [isd_pkg::NCH-1:0] cmd_dat,
  output logic [isd_pkg::NCH-1:0] cmd_frm,
  // Processor bus hold and RAM
  output logic hold_req,
  input wire logic hold_ack,
  output isd_pkg::isd_mem_t mem,
  input wire logic mem_ack,
  input wire logic [isd_pkg::DW-1:0] mem_rdata
);
  import isd_pkg::*;

  logic us_tick, sec_tick;
  logic [5:0] div_r;
  logic [19:0] usec_r;
  logic [15:0] sec_r;
  logic wr_acc, rd_setup;
  logic [OFFW-1:0] in_ptr [NCH];
  logic [OFFW-1:0] out_ptr [NCH];
  logic [AW-1:0] base_r [NCH];
  logic [3:0] cfg_r [NCH];
  logic [AW-1:0] ch_addr [NCH];
  logic [DW-1:0] wbuf [NCH];
  logic [NCH-1:0] wpend, ovr_r;
  logic [AW-1:0] cmd_base_r, cmd_ptr_r;
  logic [31:0] ent_r;
  logic cmd_rd_req, mem_done;
  logic [2:0] sel_r;
  isd_mst_t mst_r;
  isd_cst_t cst_r;
  logic [23:0] tx_sh_r;
  logic [4:0] tx_cnt_r;
  logic [NCH-1:0] tx_mask_r;
  logic tx_busy_r, ts_pend_r, guard_ok, cmd_go;
  logic [NCH:0] req;

  assign wr_acc = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign pready = 1'b1;

  // Serial bit-rate enable, one pulse per microsecond
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 6'h00;
    end else if (div_r == 6'(DIV_CYC - 1)) begin
      div_r <= 6'h00;
    end else begin
      div_r <= div_r + 6'h01;
    end
  end
  assign us_tick = (div_r == 6'(DIV_CYC - 1));
  assign sec_tick = us_tick & (usec_r == 20'(US_SEC - 1));

  // Microsecond and seconds counters
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      usec_r <= 20'h00000;
      sec_r <= 16'h0000;
    end else if (sec_tick) begin
      usec_r <= 20'h00000;
      sec_r <= sec_r + 16'h0001;
    end else if (us_tick) begin
      usec_r <= usec_r + 20'h00001;
    end
  end

  // Per-channel receive path, pointers and configuration
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_rx
      logic [OFFW-1:0] mask, wr_off, nxt_off, start_off;
      logic [15:0] sh;
      logic [3:0] bcnt;
      logic frm_q, drop, end_pend, sel_w;
      logic [OFFW-1:0] size_b;
      assign size_b = BUF_MIN << cfg_r[g][2:0];
      assign mask = size_b - 17'h00001;
      // Base bits below the size are ignored, so the buffer stays aligned
      assign ch_addr[g] = (base_r[g] & ~AW'(mask)) | AW'(wr_off);
      assign nxt_off = (wr_off + 17'h00002) & mask;
      assign sel_w = psel & (paddr[11:8] == CH_PAGE) & (paddr[7:4] == 4'(g));

      // Software writes: configuration, base and output pointer
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          cfg_r[g] <= CFG_RST;
          base_r[g] <= '0;
          out_ptr[g] <= '0;
        end else if (wr_acc && sel_w) begin
          case (paddr[3:2])
            CH_CFG: cfg_r[g] <= pwdata[3:0];
            CH_BASE: base_r[g] <= pwdata[AW-1:0];
            CH_OUT: out_ptr[g] <= pwdata[OFFW-1:0];
            default: ;
          endcase
        end
      end

      // Bit shifter: samples once per microsecond, never stalls the sender
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          sh <= 16'h0000;
          bcnt <= 4'h0;
          frm_q <= 1'b0;
        end else if (us_tick) begin
          frm_q <= rx_frm[g] & cfg_r[g][CFG_EN];
          if (rx_frm[g] && cfg_r[g][CFG_EN]) begin
            sh <= {sh[14:0], rx_dat[g]};
            bcnt <= frm_q ? bcnt + 4'h1 : 4'h1;
          end else begin
            bcnt <= 4'h0;
          end
        end
      end

      // Word hand-off, DMA pointer, block pointer and overrun
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          wbuf[g] <= 16'h0000;
          wpend[g] <= 1'b0;
          wr_off <= '0;
          in_ptr[g] <= '0;
          drop <= 1'b0;
          end_pend <= 1'b0;
          start_off <= '0;
        end else begin
          if (us_tick && rx_frm[g] && cfg_r[g][CFG_EN] && !frm_q) begin
            drop <= 1'b0;
            wr_off <= in_ptr[g];
            start_off <= in_ptr[g];
          end else if (mem_done && sel_r == 3'(g)) begin
            wpend[g] <= 1'b0;
            if (nxt_off == (out_ptr[g] & mask)) begin
              drop <= 1'b1;
              wr_off <= in_ptr[g];
            end else begin
              wr_off <= nxt_off;
            end
          end
          // A full word is queued; the one-word holder drains in far under 16 us
          if (us_tick && rx_frm[g] && frm_q && bcnt == 4'hf && !drop) begin
            wbuf[g] <= {sh[14:0], rx_dat[g]};
            wpend[g] <= 1'b1;
          end
          if (us_tick && frm_q && !rx_frm[g]) begin
            end_pend <= 1'b1;
          end else if (end_pend && !wpend[g]) begin
            end_pend <= 1'b0;
            if (!drop && wr_off != start_off) begin
              in_ptr[g] <= wr_off;
            end
          end
        end
      end

      // Sticky overrun flag; a new event beats a write-one clear
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          ovr_r[g] <= 1'b0;
        end else if (mem_done && sel_r == 3'(g) && nxt_off == (out_ptr[g] & mask)) begin
          ovr_r[g] <= 1'b1;
        end else if (wr_acc && paddr == REG_OVR && pwdata[g]) begin
          ovr_r[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // Bus hold arbiter, one transfer per hold, lowest channel first
  assign req = {cmd_rd_req, wpend};
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mst_r <= M_IDLE;
      hold_req <= 1'b0;
      sel_r <= 3'h0;
      mem <= '0;
    end else begin
      case (mst_r)
        M_IDLE: begin
          if (|req) begin
            hold_req <= 1'b1;
            mst_r <= M_HOLD;
            sel_r <= 3'(NCH);
            for (int i = NCH; i >= 0; i--) begin
              if (req[i]) begin
                sel_r <= 3'(i);
              end
            end
          end
        end
        M_HOLD: begin
          if (hold_ack) begin
            mst_r <= M_XFER;
            if (sel_r == 3'(NCH)) begin
              mem <= '{we: 1'b0, re: 1'b1, addr: cmd_ptr_r, wdata: 16'h0000};
            end else begin
              mem <= '{we: 1'b1, re: 1'b0, addr: ch_addr[sel_r], wdata: wbuf[sel_r]};
            end
          end
        end
        M_XFER: begin
          if (mem_ack) begin
            mem.we <= 1'b0;
            mem.re <= 1'b0;
            hold_req <= 1'b0;
            mst_r <= M_REL;
          end
        end
        M_REL: begin
          if (!hold_ack) begin
            mst_r <= M_IDLE;
          end
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end
  assign mem_done = (mst_r == M_XFER) & mem_ack;

  // Start a command only if it ends before the time-stamp slot
  assign guard_ok = (usec_r + GUARD_US) < 20'(US_SEC);
  assign cmd_go = (cst_r == C_CHK) & ~tx_busy_r & ~ts_pend_r & guard_ok
                  & (ent_r[PFX_HI:PFX_LO] < 8'(NCH)) & us_tick;

  // Command list fetcher
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cst_r <= C_IDLE;
      cmd_base_r <= '0;
      cmd_ptr_r <= '0;
      ent_r <= 32'h00000000;
      cmd_rd_req <= 1'b0;
    end else begin
      if (wr_acc && paddr == REG_CMD_BASE) begin
        cmd_base_r <= pwdata[AW-1:0];
      end
      if (mem_done && sel_r == 3'(NCH)) begin
        cmd_rd_req <= 1'b0;
        cmd_ptr_r <= cmd_ptr_r + 22'h000002;
      end
      case (cst_r)
        C_IDLE: begin
          if (wr_acc && paddr == REG_CTRL && pwdata[CTRL_GO]) begin
            cmd_ptr_r <= cmd_base_r;
            cmd_rd_req <= 1'b1;
            cst_r <= C_FHI;
          end
        end
        C_FHI: begin
          if (mem_done && sel_r == 3'(NCH)) begin
            ent_r[31:16] <= mem_rdata;
            cmd_rd_req <= 1'b1;
            cst_r <= C_FLO;
          end
        end
        C_FLO: begin
          if (mem_done && sel_r == 3'(NCH)) begin
            ent_r[15:0] <= mem_rdata;
            cst_r <= C_CHK;
          end
        end
        C_CHK: begin
          if (ent_r[PFX_HI:PFX_LO] == PFX_END) begin
            cst_r <= C_IDLE;
          end else if (cmd_go || ent_r[PFX_HI:PFX_LO] >= 8'(NCH)) begin
            cmd_rd_req <= 1'b1; // Unknown targets are skipped
            cst_r <= C_FHI;
          end
        end
        default: cst_r <= C_IDLE;
      endcase
    end
  end

  // Shared transmitter; frames start on a bit tick so the first bit is full
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_sh_r <= 24'h000000;
      tx_cnt_r <= 5'h00;
      tx_mask_r <= '0;
      tx_busy_r <= 1'b0;
      ts_pend_r <= 1'b0;
    end else begin
      if (sec_tick) begin
        ts_pend_r <= 1'b1;
      end else if (ts_pend_r && !tx_busy_r && us_tick) begin
        ts_pend_r <= 1'b0;
        tx_sh_r <= {TS_OPCODE, sec_r};
        tx_mask_r <= '1;
        tx_busy_r <= 1'b1;
        tx_cnt_r <= 5'h00;
      end else if (cmd_go) begin
        tx_sh_r <= ent_r[23:0];
        tx_mask_r <= NCH'(1) << ent_r[26:24];
        tx_busy_r <= 1'b1;
        tx_cnt_r <= 5'h00;
      end
      if (tx_busy_r && us_tick) begin
        tx_sh_r <= {tx_sh_r[22:0], 1'b0};
        tx_cnt_r <= tx_cnt_r + 5'h01;
        if (tx_cnt_r == 5'(CMD_BITS - 1)) begin
          tx_busy_r <= 1'b0;
        end
      end
    end
  end

  // Steered serial outputs, registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_dat <= '0;
      cmd_frm <= '0;
    end else begin
      cmd_frm <= tx_busy_r ? tx_mask_r : '0;
      cmd_dat <= tx_busy_r ? (tx_mask_r & {NCH{tx_sh_r[23]}}) : '0;
    end
  end

  // Read data captured in the setup cycle, zero-wait access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (paddr[11:8] == CH_PAGE && paddr[7:4] < 4'(NCH) && paddr[1:0] == 2'h0) begin
        if (rd_setup) begin
          case (paddr[3:2])
            CH_CFG: prdata <= 32'(cfg_r[paddr[6:4]]);
            CH_BASE: prdata <= 32'(base_r[paddr[6:4]]);
            CH_IN: prdata <= 32'(in_ptr[paddr[6:4]]);
            default: prdata <= 32'(out_ptr[paddr[6:4]]);
          endcase
        end
      end else if (paddr == REG_CTRL) begin
        prdata <= {31'h00000000, cst_r != C_IDLE};
      end else if (paddr == REG_CMD_BASE) begin
        prdata <= 32'(cmd_base_r);
      end else if (paddr == REG_SECONDS) begin
        prdata <= 32'(sec_r);
      end else if (paddr == REG_USEC) begin
        prdata <= 32'(usec_r);
      end else if (paddr == REG_OVR) begin
        prdata <= 32'(ovr_r);
      end else begin
        pslverr <= 1'b1; // Unmapped address
      end
    end
  end
endmodule : isd_dma
`default_nettype wire

// File: verilog/isd_pkg.sv
// Constants, register map and carriers for the instrument serial DMA block
// Behaviour
// - Five identical serial instrument interfaces.
// - Received words go to RAM by DMA.
// - Sustain 1 Mbps input, never throttle sender.
// - Receive buffers wrap without software help.
// - Buffer size 1k to 128k, eight powers.
// - Buffer base aligned to its own size.
// - Input pointer marks latest completed block.
// - Input pointer advances on each completed block.
// - Input reaching output pointer flags overrun.
// - One command sequencer steered to target.
// - Time-stamp command sent autonomously to all.
// - No command start overlapping time-stamp slot.
// - 32-bit entries: 8-bit prefix, 24-bit word.
// - Stop on end-of-list prefix.
// - Overrun drops block, rewinds input pointer.
// - Each channel owns a DMA address pointer.
// - Bus hold, transfer, release; arbitrate channels.
// - Time-stamp carries readable 16-bit seconds count.
package isd_pkg;
  localparam int NCH = 5;
  localparam int AW = 22;
  localparam int DW = 16;
  localparam int OFFW = 17;
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int SER_HZ = 1000000;
  localparam int DIV_CYC = CLK_HZ / SER_HZ;
  localparam int US_PER_SEC = 1000000;
  localparam int CMD_BITS = 24;
  localparam logic [19:0] GUARD_US = 20'h0001a;
  // Command entry layout
  localparam int PFX_HI = 31;
  localparam int PFX_LO = 24;
  localparam logic [7:0] PFX_END = 8'hff;
  localparam logic [7:0] TS_OPCODE = 8'ha5;
  // Buffer size base in bytes
  localparam logic [OFFW-1:0] BUF_MIN = 17'h00400;
  // Register byte offsets
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_CMD_BASE = 12'h004;
  localparam logic [11:0] REG_SECONDS = 12'h008;
  localparam logic [11:0] REG_USEC = 12'h00c;
  localparam logic [11:0] REG_OVR = 12'h010;
  localparam logic [3:0] CH_PAGE = 4'h1;
  localparam logic [1:0] CH_CFG = 2'h0;
  localparam logic [1:0] CH_BASE = 2'h1;
  localparam logic [1:0] CH_IN = 2'h2;
  localparam logic [1:0] CH_OUT = 2'h3;
  // Field positions
  localparam int CTRL_GO = 0;
  localparam int CFG_EN = 3;
  localparam logic [3:0] CFG_RST = 4'h0;
  typedef enum {M_IDLE, M_HOLD, M_XFER, M_REL} isd_mst_t;
  typedef enum {C_IDLE, C_FHI, C_FLO, C_CHK} isd_cst_t;
  // Memory request toward the board RAM
  typedef struct packed {
    logic we;
    logic re;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } isd_mem_t;
endpackage : isd_pkg

// File: test/isd_dma_sva.sv
// Port checker for the serial DMA block
`timescale 1ns/1ps
`default_nettype none
module isd_dma_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Command lines
  input wire logic [isd_pkg::NCH-1:0] cmd_dat,
  input wire logic [isd_pkg::NCH-1:0] cmd_frm,
  // Bus hold and RAM
  input wire logic hold_req,
  input wire logic hold_ack,
  input wire isd_pkg::isd_mem_t mem,
  input wire logic mem_ack
);
  import isd_pkg::*;
  logic stb;
  logic [10:0] frm_cnt_r;
  // Either strobe counts as a bus cycle
  assign stb = mem.we | mem.re;
  // Frame length, since a 24-bit word at 40 clocks a bit caps it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      frm_cnt_r <= 11'h000;
    else if (|cmd_frm)
      frm_cnt_r <= frm_cnt_r + 11'h001;
    else
      frm_cnt_r <= 11'h000;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_strobe_has_hold: assert property (stb |-> hold_req)
    else $error("strobe without bus hold");
  a_grant_before_strobe: assert property ($rose(stb) |-> $past(hold_ack))
    else $error("strobe before grant");
  a_strobe_held: assert property (stb && !mem_ack |=> stb)
    else $error("strobe dropped before ack");
  a_release_after_ack: assert property (stb && mem_ack |=> !stb && !hold_req)
    else $error("bus not released after ack");
  a_word_aligned: assert property (stb |-> !mem.addr[0])
    else $error("odd memory address");
  a_bit_stands: assert property ((|cmd_frm) && $changed(cmd_dat) |=> $stable(cmd_dat) [*8])
    else $error("command bit too short");
  a_frame_bound: assert property (frm_cnt_r <= 11'h3c0)
    else $error("command frame too long");
  a_steer_target: assert property ($onehot0(cmd_frm) || (&cmd_frm))
    else $error("bad command steering");
endmodule : isd_dma_sva
bind isd_dma isd_dma_sva u_isd_dma_sva (
  .mclk(mclk),
  .rst_n(rst_n),
  .cmd_dat(cmd_dat),
  .cmd_frm(cmd_frm),
  .hold_req(hold_req),
  .hold_ack(hold_ack),
  .mem(mem),
  .mem_ack(mem_ack)
);
`default_nettype wire

// File: test/isd_ram_model.sv
// Board RAM and processor bus hold model
`timescale 1ns/1ps
`default_nettype none
module isd_ram_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Slow answer select
  input wire logic slow,
  // Bus hold and RAM port
  input wire logic hold_req,
  output logic hold_ack,
  input wire isd_pkg::isd_mem_t mem,
  output logic mem_ack,
  output logic [isd_pkg::DW-1:0] mem_rdata
);
  import isd_pkg::*;
  logic [15:0] ram [0:4095];
  logic [2:0] wait_r;
  // Grant tracks request; slow mode stretches each transfer
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hold_ack <= 1'b0;
      mem_ack <= 1'b0;
      wait_r <= 3'h0;
      mem_rdata <= 16'h0000;
    end else begin
      hold_ack <= hold_req;
      if ((mem.we || mem.re) && !mem_ack && wait_r != 3'h0) begin
        wait_r <= wait_r - 3'h1;
      end else if ((mem.we || mem.re) && !mem_ack) begin
        mem_ack <= 1'b1;
        if (mem.we)
          ram[mem.addr[11:0]] <= mem.wdata;
        mem_rdata <= ram[mem.addr[11:0]];
      end else begin
        mem_ack <= 1'b0;
        wait_r <= slow ? 3'h3 : 3'h0;
        mem_rdata <= ~mem_rdata; // Bus released, no stale data
      end
    end
  end
endmodule : isd_ram_model
`default_nettype wire

// File: test/instrument_serial_dma_bench.sv
// Testbench for the serial DMA block
`timescale 1ns/1ps
`default_nettype none
module instrument_serial_dma_bench;
  import isd_pkg::*;
  localparam int US = 200;
  typedef struct packed {
    logic wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic err;
  } isd_row_t;
  localparam isd_row_t ROWS [7] = '{
    '{1'b0, 12'h000, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h004, 32'hffffffff, 32'h003fffff, 1'b0},
    '{1'b0, 12'h010, 32'h0, 32'h0, 1'b0},
    '{1'b1, 12'h100, 32'h000000ff, 32'h0000000f, 1'b0},
    '{1'b1, 12'h148, 32'h00001234, 32'h0, 1'b0},
    '{1'b1, 12'h14c, 32'hffffffff, 32'h0001ffff, 1'b0},
    '{1'b1, 12'h150, 32'h1, 32'h0, 1'b1}
  };
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, slow;
  logic hold_req, hold_ack, mem_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [NCH-1:0] rx_dat, rx_frm, cmd_dat, cmd_frm;
  logic [DW-1:0] mem_rdata;
  logic [23:0] b;
  logic [4:0] frm;
  logic e;
  isd_mem_t mem;
  int n_errors, n_checks, cyc;
  isd_dma #(.US_SEC(US)) u_isd_dma (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_dat(rx_dat), .rx_frm(rx_frm), .cmd_dat(cmd_dat),
    .cmd_frm(cmd_frm), .hold_req(hold_req), .hold_ack(hold_ack), .mem(mem),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  isd_ram_model u_isd_ram_model (.mclk(mclk), .rst_n(rst_n), .slow(slow),
    .hold_req(hold_req), .hold_ack(hold_ack), .mem(mem), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // Clock at 40 MHz
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  // Cuts a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One APB transfer, request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Two words on channel 0, MSB first, one bit per microsecond
  task automatic rx_blk(input logic [31:0] w);
    @(posedge mclk);
    rx_frm[0] <= 1'b1;
    for (int i = 31; i >= 0; i--) begin
      rx_dat[0] <= w[i];
      repeat (DIV_CYC) @(posedge mclk);
    end
    rx_frm[0] <= 1'b0;
    rx_dat[0] <= ~w[0];
    repeat (80) @(posedge mclk);
  endtask : rx_blk
  // Wait for a frame start, then sample each bit mid-way
  task automatic cap(input int ch);
    for (int i = 0; i < 9000 && (|cmd_frm) !== 1'b1; i++)
      @(posedge mclk);
    frm = cmd_frm;
    for (int i = 23; i >= 0; i--) begin
      repeat (DIV_CYC / 2) @(posedge mclk);
      b[i] = cmd_dat[ch];
      repeat (DIV_CYC - DIV_CYC / 2) @(posedge mclk);
    end
    while ((|cmd_frm) === 1'b1)
      @(posedge mclk);
  endtask : cap
  initial begin
    {psel, penable, pwrite, slow, rst_n} = 5'h00;
    {paddr, pwdata, rx_dat, rx_frm, n_errors, n_checks} = '0;
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    chk("hold_req", hold_req, 1'b0);
    // Register rows
    foreach (ROWS[i]) begin
      if (ROWS[i].wr)
        apb(1'b1, ROWS[i].a, ROWS[i].d);
      apb(1'b0, ROWS[i].a, 32'h0);
      chk("row data", r, ROWS[i].e);
      chk("row err", e, ROWS[i].err);
    end
    $display("test registers done");
    // Receive one block into a 1 KB buffer at 0x400
    apb(1'b1, 12'h100, 32'h8);
    apb(1'b1, 12'h104, 32'h400);
    apb(1'b1, 12'h10c, 32'h0);
    rx_blk(32'hc3a55a3c);
    chk("ram 400", u_isd_ram_model.ram[12'h400], 16'hc3a5);
    chk("ram 402", u_isd_ram_model.ram[12'h402], 16'h5a3c);
    apb(1'b0, 12'h108, 32'h0);
    chk("in ptr", r, 32'h4);
    $display("test receive done");
    // Output pointer just ahead: block must be dropped
    apb(1'b1, 12'h10c, 32'h6);
    rx_blk(32'h12345678);
    apb(1'b0, 12'h010, 32'h0);
    chk("overrun", r, 32'h1);
    apb(1'b0, 12'h108, 32'h0);
    chk("rewound ptr", r, 32'h4);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b0, 12'h010, 32'h0);
    chk("overrun clr", r, 32'h0);
    $display("test overrun done");
    // Command list started just before the time-stamp slot
    u_isd_ram_model.ram[12'h800] = 16'h0212;
    u_isd_ram_model.ram[12'h802] = 16'h3456;
    u_isd_ram_model.ram[12'h804] = 16'hff00;
    slow <= 1'b1;
    apb(1'b1, 12'h004, 32'h800);
    for (int k = 0; k < 20000; k++) begin
      apb(1'b0, 12'h00c, 32'h0);
      if (r >= US - 20 && r < US - 8)
        break;
    end
    apb(1'b1, 12'h000, 32'h1);
    apb(1'b0, 12'h000, 32'h0);
    chk("busy", r, 32'h1);
    cap(4);
    chk("first frame", frm, 5'h1f);
    apb(1'b0, 12'h008, 32'h0);
    chk("seconds", r, 32'h1);
    chk("stamp", b, {TS_OPCODE, 16'h0001});
    cap(2);
    chk("steer", frm, 5'h04);
    chk("command", b, 24'h123456);
    for (int k = 0; k < 200 && (k == 0 || r[0] !== 1'b0); k++)
      apb(1'b0, 12'h000, 32'h0);
    chk("stopped", r, 32'h0);
    $display("test command done");
    // Reset in mid-run must bring channel 0 output pointer and configuration back to idle
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h10c, 32'h0);
    chk("reset out ptr", r, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk("reset cfg", r, 32'h0);
    $display("test reset done");
    give_verdict();
  end
endmodule : instrument_serial_dma_bench
`default_nettype wire
